/* hdl/oamfm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oamfm_defines.svh"
module oamfm_top (
	input wire logic clk_sys,
	input wire logic nrst,
	// static context write
	input wire logic ctxWrEn,
	input wire logic ctxWrDir,
	input wire logic [`OAMFM_IW-1:0] ctxWrIdx,
	input wire logic [`OAMFM_SW-1:0] ctxWrData,
	// flag read and clear
	input wire logic [`OAMFM_IW-1:0] flgRdIdx,
	output logic [7:0] flgRdData,
	input wire logic flgClrEn,
	input wire logic [`OAMFM_IW-1:0] flgClrIdx,
	input wire logic [7:0] flgClrMask,
	// scan control
	input wire logic scanStart,
	input wire logic [7:0] scanEnable,
	input wire logic [`OAMFM_IW-1:0] contextHighestRecord,
	input wire logic scanDoneClr,
	output logic scanDoneFlag,
	output logic scanBusy,
	// generated cells, index 0 egress, 1 ingress
	output logic [1:0] genValid,
	input wire logic [1:0] genReady,
	output logic [1:0][`OAMFM_IW-1:0] genConn,
	output logic [1:0][1:0] genType,
	output logic [1:0] genE2e,
	output logic [7:0] genFillOctet,
	// received cells
	input wire logic [1:0] rxValid,
	input wire logic [1:0][`OAMFM_IW-1:0] rxConn,
	input wire logic [1:0][2:0] rxKind,
	input wire logic [1:0] rxSegment,
	output logic [1:0] rxDoneValid,
	output logic [1:0] rxCopy,
	output logic [1:0] rxRemove
);
	// =====================================
	// state and helpers
	oamfm_pkg::oamfm_state_t st_r; // registered state
	oamfm_pkg::oamfm_state_t st_nxt; // next state
	logic [1:0][5:0] rxEv; // per direction decode
	logic [1:0][3:0] clrM; // clear mask row
	logic [1:0][3:0] setM; // set mask row

	// enable bit for type t in direction d
	function automatic logic [2:0] en_idx(input int d, input int t);
		en_idx = 3'((t * 2) + d);
	endfunction

	// lowest pending type
	function automatic logic [1:0] pick_low(input logic [3:0] m);
		pick_low = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (m[i]) begin
				pick_low = 2'(i);
			end
		end
	endfunction

	// classify one received cell: {flag set[3:0], copy, remove}
	// payload failure fields never reach this decode
	function automatic logic [5:0] rx_eval(
		input logic [`OAMFM_SW-1:0] c,
		input logic [2:0] k,
		input logic seg
	);
		logic [3:0] s;
		logic cp;
		logic rm;
		logic oam;
		s = 4'h0;
		cp = 1'b0;
		rm = 1'b0;
		oam = (k != oamfm_pkg::RX_USER);
		case (k)
			oamfm_pkg::RX_USER: begin
				// channel record of a path end too
				s[`OAMFM_FB_SEG] = 1'b1;
				s[`OAMFM_FB_E2E] = 1'b1;
			end
			oamfm_pkg::RX_AIS: begin
				// segment flavour is generic OAM only
				s[`OAMFM_FB_AIS] = !seg;
				cp = !seg && c[`OAMFM_SB_CAIS];
			end
			oamfm_pkg::RX_RDI: begin
				s[`OAMFM_FB_RDI] = !seg;
				cp = !seg && c[`OAMFM_SB_CRDI];
			end
			oamfm_pkg::RX_CC: begin
				// separate flags keep both checks apart
				s[`OAMFM_FB_SEG] = 1'b1;
				s[`OAMFM_FB_E2E] = !seg;
			end
			default: begin
				s = 4'h0;
			end
		endcase
		// copy-all catches every OAM cell
		cp = cp || (oam && c[`OAMFM_SB_CALL]);
		// endpoint removal by termination bits
		if (oam) begin
			rm = seg ? c[`OAMFM_SB_SEGT] : c[`OAMFM_SB_E2ET];
		end
		rx_eval = {s, cp, rm};
	endfunction

	// =====================================
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.fill = `OAMFM_FILL;
		st_nxt.rxDone = rxValid;
		// receive path, one cell per direction per cycle
		for (int d = 0; d < 2; d++) begin
			rxEv[d] = rx_eval(st_r.ctx[d][rxConn[d]], rxKind[d], rxSegment[d]);
			st_nxt.rxCopy[d] = rxValid[d] && rxEv[d][1];
			st_nxt.rxRemove[d] = rxValid[d] && rxEv[d][0];
		end
		// flag rows: sticky, set beats a same-cycle clear
		for (int d = 0; d < 2; d++) begin
			for (int r = 0; r < `OAMFM_NREC; r++) begin
				clrM[d] = (flgClrEn && (flgClrIdx == 4'(r))) ? flgClrMask[d*4 +: 4] : 4'h0;
				setM[d] = (rxValid[d] && (rxConn[d] == 4'(r))) ? rxEv[d][5:2] : 4'h0;
				st_nxt.flg[d][r] = (st_r.flg[d][r] & ~clrM[d]) | setM[d];
			end
		end
		// host writes static bits
		if (ctxWrEn) begin
			st_nxt.ctx[ctxWrDir][ctxWrIdx] = ctxWrData;
		end
		// polled flag view, both directions
		st_nxt.flgRd = {st_r.flg[1][flgRdIdx], st_r.flg[0][flgRdIdx]};
		// done flag clear, set below wins
		if (scanDoneClr) begin
			st_nxt.scanDone = 1'b0;
		end
		// scan sequencer
		case (st_r.st)
			oamfm_pkg::SC_IDLE: begin
				// idle until started
				if (scanStart) begin
					st_nxt.rec = contextHighestRecord;
					st_nxt.busy = 1'b1;
					st_nxt.st = oamfm_pkg::SC_LOAD;
				end
			end
			oamfm_pkg::SC_LOAD: begin
				// gather enabled send bits of this record
				for (int d = 0; d < 2; d++) begin
					for (int t = 0; t < 4; t++) begin
						st_nxt.pend[d][t] = st_r.ctx[d][st_r.rec][t] && scanEnable[en_idx(d, t)];
					end
				end
				st_nxt.st = oamfm_pkg::SC_RUN;
			end
			oamfm_pkg::SC_RUN: begin
				// each direction feeds its own flow
				for (int d = 0; d < 2; d++) begin
					if (st_r.genValid[d] && genReady[d]) begin
						st_nxt.genValid[d] = 1'b0;
					end
					if (!st_nxt.genValid[d] && (st_r.pend[d] != 4'h0)) begin
						st_nxt.genValid[d] = 1'b1;
						st_nxt.genConn[d] = st_r.rec;
						st_nxt.genType[d] = pick_low(st_r.pend[d]);
						st_nxt.pend[d][pick_low(st_r.pend[d])] = 1'b0;
					end
				end
				// record finished once all its cells taken
				if ((st_r.pend == 8'h00) && ((st_r.genValid & ~genReady) == 2'h0)) begin
					if (st_r.rec == 4'h0) begin
						st_nxt.scanDone = 1'b1;
						st_nxt.busy = 1'b0;
						st_nxt.st = oamfm_pkg::SC_IDLE;
					end else begin
						st_nxt.rec = st_r.rec - 4'h1;
						st_nxt.st = oamfm_pkg::SC_LOAD;
					end
				end
			end
			default: begin
				st_nxt.st = oamfm_pkg::SC_IDLE;
			end
		endcase
	end

	// =====================================
	// state register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// =====================================
	// outputs from flops, genE2e decoded from the registered type
	assign flgRdData = st_r.flgRd;
	assign scanDoneFlag = st_r.scanDone;
	assign scanBusy = st_r.busy;
	assign genValid = st_r.genValid;
	assign genConn = st_r.genConn;
	assign genType = st_r.genType;
	// only segment CC is not end-to-end
	assign genE2e[0] = st_r.genType[0] != oamfm_pkg::GEN_CCS;
	assign genE2e[1] = st_r.genType[1] != oamfm_pkg::GEN_CCS;
	assign genFillOctet = st_r.fill;
	assign rxDoneValid = st_r.rxDone;
	assign rxCopy = st_r.rxCopy;
	assign rxRemove = st_r.rxRemove;

	// =====================================
	// assertions
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	// end of last record with nothing outstanding
	sequence lastRecClear;
		st_r.st == oamfm_pkg::SC_RUN && st_r.rec == 4'h0 && st_r.pend == 8'h00
			&& (st_r.genValid & ~genReady) == 2'h0;
	endsequence
	sequence doneShown;
		scanDoneFlag && !scanBusy ##0 st_r.st == oamfm_pkg::SC_IDLE;
	endsequence

	scan_done_a: assert property (lastRecClear |=> doneShown)
		else $error("scan done not raised after record zero");
	scan_down_a: assert property (st_r.st == oamfm_pkg::SC_RUN && st_r.rec != 4'h0
		&& st_r.pend == 8'h00 && (st_r.genValid & ~genReady) == 2'h0
		|=> st_r.st == oamfm_pkg::SC_LOAD && st_r.rec == $past(st_r.rec) - 4'h1)
		else $error("scan did not step to next lower record");
	gen_fill_a: assert property (genValid != 2'h0 |-> genFillOctet == 8'h6A)
		else $error("generated cell fill octet wrong");
	// a start while idle loads the top record
	scan_start_a: assert property (st_r.st == oamfm_pkg::SC_IDLE && scanStart
		|=> scanBusy && st_r.st == oamfm_pkg::SC_LOAD
		&& st_r.rec == $past(contextHighestRecord))
		else $error("scan start did not load highest record");
	// no cell is offered outside a scan pass
	idle_quiet_a: assert property (!scanBusy |-> genValid == 2'h0)
		else $error("cell offered while scan idle");

	for (genvar d = 0; d < 2; d++) begin : g_chk
		gen_hold_a: assert property (genValid[d] && !genReady[d]
			|=> genValid[d] && $stable(genType[d]) && $stable(genConn[d]))
			else $error("generated cell dropped before acceptance");
		ais_flag_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_AIS
			&& !rxSegment[d] |=> st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_AIS])
			else $error("receive AIS flag not set");
		rdi_flag_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_RDI
			&& !rxSegment[d] |=> st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_RDI])
			else $error("receive RDI flag not set");
		user_traffic_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_USER
			|=> st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_E2E]
			&& st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_SEG] && !rxRemove[d])
			else $error("user cell did not set both traffic flags");
		seg_copy_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_AIS
			&& rxSegment[d] && !st_r.ctx[d][rxConn[d]][`OAMFM_SB_CALL] |=> !rxCopy[d])
			else $error("segment AIS copied without copy-all");
		ais_copy_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_AIS
			&& !rxSegment[d] && st_r.ctx[d][rxConn[d]][`OAMFM_SB_CAIS] |=> rxCopy[d])
			else $error("AIS not copied with copy bit set");
		e2e_remove_a: assert property (rxValid[d] && rxKind[d] != oamfm_pkg::RX_USER
			&& !rxSegment[d] && st_r.ctx[d][rxConn[d]][`OAMFM_SB_E2ET]
			|=> rxRemove[d] && rxDoneValid[d])
			else $error("end-to-end OAM not removed at endpoint");
		rdi_copy_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_RDI
			&& !rxSegment[d] && st_r.ctx[d][rxConn[d]][`OAMFM_SB_CRDI] |=> rxCopy[d])
			else $error("RDI not copied with copy bit set");
		// segment flavours never touch the alarm flags
		seg_ais_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_AIS
			&& rxSegment[d] && !st_r.flg[d][rxConn[d]][`OAMFM_FB_AIS]
			|=> !st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_AIS])
			else $error("segment AIS set receive AIS flag");
		seg_rdi_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_RDI
			&& rxSegment[d] && !st_r.flg[d][rxConn[d]][`OAMFM_FB_RDI]
			|=> !st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_RDI])
			else $error("segment RDI set receive RDI flag");
		// segment CC leaves the end-to-end flag as it was
		seg_cc_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_CC
			&& rxSegment[d] && !st_r.flg[d][rxConn[d]][`OAMFM_FB_E2E]
			|=> st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_SEG]
			&& !st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_E2E])
			else $error("segment CC traffic flags wrong");
		cc_e2e_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_CC
			&& !rxSegment[d] |=> st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_SEG]
			&& st_r.flg[d][$past(rxConn[d])][`OAMFM_FB_E2E])
			else $error("end-to-end CC did not set both traffic flags");
		// segment endpoint takes segment OAM out of the flow
		seg_remove_a: assert property (rxValid[d] && rxKind[d] != oamfm_pkg::RX_USER
			&& rxSegment[d] && st_r.ctx[d][rxConn[d]][`OAMFM_SB_SEGT] |=> rxRemove[d])
			else $error("segment OAM not removed at segment endpoint");
		// away from the endpoint AIS passes on
		ais_pass_a: assert property (rxValid[d] && rxKind[d] == oamfm_pkg::RX_AIS
			&& !rxSegment[d] && !st_r.ctx[d][rxConn[d]][`OAMFM_SB_E2ET] |=> !rxRemove[d])
			else $error("AIS removed away from endpoint");
		// flags only fall through an explicit clear
		for (genvar r = 0; r < `OAMFM_NREC; r++) begin : g_rec
			flag_sticky_a: assert property (!(flgClrEn && flgClrIdx == 4'(r))
				|=> (st_r.flg[d][r] & $past(st_r.flg[d][r])) == $past(st_r.flg[d][r]))
				else $error("receive flag fell without a clear");
		end
		for (genvar t = 0; t < 4; t++) begin : g_typ
			scan_pick_a: assert property (st_r.st == oamfm_pkg::SC_LOAD
				&& st_r.ctx[d][st_r.rec][t] && scanEnable[t*2+d]
				|=> st_r.pend[d][t])
				else $error("enabled send bit not queued");
		end
	end
endmodule // oamfm_top
`default_nettype wire

/* hdl/oamfm_defines.svh */
`ifndef OAMFM_DEFINES_SVH
`define OAMFM_DEFINES_SVH
// =====================================
// table geometry
`define OAMFM_NREC 16
`define OAMFM_IW 4
// =====================================
// static context word, per direction
`define OAMFM_SW 9
`define OAMFM_SB_SAIS 0
`define OAMFM_SB_SRDI 1
`define OAMFM_SB_SCCS 2
`define OAMFM_SB_SCCE 3
`define OAMFM_SB_CAIS 4
`define OAMFM_SB_CRDI 5
`define OAMFM_SB_CALL 6
`define OAMFM_SB_E2ET 7
`define OAMFM_SB_SEGT 8
// =====================================
// dynamic flag word, per direction
`define OAMFM_FW 4
`define OAMFM_FB_AIS 0
`define OAMFM_FB_RDI 1
`define OAMFM_FB_SEG 2
`define OAMFM_FB_E2E 3
// =====================================
// reset values and fill pattern
`define OAMFM_CTX_RST 9'h000
`define OAMFM_FLG_RST 4'h0
`define OAMFM_FILL 8'h6A
`endif

/* hdl/oamfm_pkg.sv */
`include "oamfm_defines.svh"
package oamfm_pkg;
	// scan sequencer states
	typedef enum logic [1:0] {
		SC_IDLE = 2'b00,
		SC_LOAD = 2'b01,
		SC_RUN = 2'b10
	} oamfm_scan_t;
	// generated cell kind, equals send bit position
	typedef enum logic [1:0] {
		GEN_AIS = 2'b00,
		GEN_RDI = 2'b01,
		GEN_CCS = 2'b10,
		GEN_CCE = 2'b11
	} oamfm_gen_t;
	// received cell class
	typedef enum logic [2:0] {
		RX_USER = 3'b000,
		RX_AIS = 3'b001,
		RX_RDI = 3'b010,
		RX_CC = 3'b011,
		RX_OTHER = 3'b100
	} oamfm_rx_t;
	// whole block state
	typedef struct packed {
		oamfm_scan_t st;
		logic [`OAMFM_IW-1:0] rec;
		logic [1:0][3:0] pend;
		logic [1:0][`OAMFM_NREC-1:0][`OAMFM_SW-1:0] ctx;
		logic [1:0][`OAMFM_NREC-1:0][`OAMFM_FW-1:0] flg;
		logic [1:0] genValid;
		logic [1:0][`OAMFM_IW-1:0] genConn;
		logic [1:0][1:0] genType;
		logic [7:0] fill;
		logic [1:0] rxDone;
		logic [1:0] rxCopy;
		logic [1:0] rxRemove;
		logic [7:0] flgRd;
		logic scanDone;
		logic busy;
	} oamfm_state_t;
endpackage

/* dv/oamfm_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// insertion queue model, takes generated cells
module oamfm_sink (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic slow,
	input wire logic [1:0] genValid,
	output logic [1:0] genReady
);
	// ready per flow: always, or random stalls on a waiting cell when slow
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			genReady <= 2'b00;
		end else if (slow) begin
			genReady <= 2'($urandom) | ~genValid;
		end else begin
			genReady <= 2'b11;
		end
	end
endmodule // oamfm_sink
`default_nettype wire

/* dv/test_oamfm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oamfm_defines.svh"
module test_oamfm_top;
	// ==========================================
	// signals
	logic clk_sys, nrst, ctxWrEn, ctxWrDir, flgClrEn, scanStart, scanDoneClr, slow;
	logic scanDoneFlag, scanBusy;
	logic [3:0] ctxWrIdx, flgRdIdx, flgClrIdx, contextHighestRecord;
	logic [8:0] ctxWrData;
	logic [7:0] flgRdData, flgClrMask, scanEnable, genFillOctet;
	logic [1:0] genValid, genReady, genE2e, rxValid, rxSegment, rxDoneValid, rxCopy, rxRemove;
	logic [1:0][3:0] genConn, rxConn;
	logic [1:0][1:0] genType;
	logic [1:0][2:0] rxKind;
	logic [8:0] sc[2][16]; // shadow context
	logic [3:0] ef[2][16]; // expected flags
	logic [5:0] gq[2][$]; // expected cells {rec,type}
	logic [1:0] rq[2][$]; // expected {copy,remove}
	int errCount = 0, numChecks = 0, cyc = 0, k;
	logic [5:0] e;
	oamfm_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .ctxWrEn(ctxWrEn), .ctxWrDir(ctxWrDir),
		.ctxWrIdx(ctxWrIdx), .ctxWrData(ctxWrData), .flgRdIdx(flgRdIdx), .flgRdData(flgRdData),
		.flgClrEn(flgClrEn), .flgClrIdx(flgClrIdx), .flgClrMask(flgClrMask),
		.scanStart(scanStart), .scanEnable(scanEnable), .contextHighestRecord(contextHighestRecord),
		.scanDoneClr(scanDoneClr), .scanDoneFlag(scanDoneFlag), .scanBusy(scanBusy),
		.genValid(genValid), .genReady(genReady), .genConn(genConn), .genType(genType),
		.genE2e(genE2e), .genFillOctet(genFillOctet), .rxValid(rxValid), .rxConn(rxConn),
		.rxKind(rxKind), .rxSegment(rxSegment), .rxDoneValid(rxDoneValid), .rxCopy(rxCopy),
		.rxRemove(rxRemove));
	oamfm_sink u_sink (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .genValid(genValid),
		.genReady(genReady));
	// ==========================================
	// tasks
	task automatic chk(string n, logic [31:0] x, logic [31:0] g);
		numChecks++;
		if (x !== g) begin
			errCount++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	task wrapUp;
		if (errCount == 0 && numChecks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(int d, int i, logic [8:0] v);
		@(posedge clk_sys) {ctxWrEn, ctxWrDir, ctxWrIdx, ctxWrData} <= {1'b1, d[0], i[3:0], v};
		@(posedge clk_sys) ctxWrEn <= 1'b0;
		sc[d][i] = v;
	endtask
	// one received cell plus its expected outcome
	task rx(int d, int c, int k, logic s);
		logic [8:0] v;
		logic ai, ri;
		v = sc[d][c];
		ai = k == 1 && !s; // e2e AIS only
		ri = k == 2 && !s; // e2e RDI only
		rq[d].push_back({(k != 0 && v[`OAMFM_SB_CALL]) || (ai && v[`OAMFM_SB_CAIS]) ||
			(ri && v[`OAMFM_SB_CRDI]), k != 0 && (s ? v[`OAMFM_SB_SEGT] : v[`OAMFM_SB_E2ET])});
		if (ai) ef[d][c][0] = 1'b1;
		if (ri) ef[d][c][1] = 1'b1;
		if (k == 0 || k == 3) ef[d][c][2] = 1'b1;
		if (k == 0 || (k == 3 && !s)) ef[d][c][3] = 1'b1;
		@(posedge clk_sys) begin
			rxValid[d] <= 1'b1;
			rxConn[d] <= c[3:0];
			rxKind[d] <= k[2:0];
			rxSegment[d] <= s;
		end
		@(posedge clk_sys) rxValid[d] <= 1'b0;
	endtask
	task rdall;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys) flgRdIdx <= i[3:0];
			repeat (2) @(posedge clk_sys);
			chk("flags", {ef[1][i], ef[0][i]}, flgRdData);
		end
		chk("rxleft", 0, rq[0].size() + rq[1].size());
	endtask
	task scan(logic [3:0] hi, logic [7:0] en);
		int w;
		for (int r = hi; r >= 0; r--)
			for (int d = 0; d < 2; d++)
				for (int t = 0; t < 4; t++)
					if (sc[d][r][t] && en[t*2+d]) gq[d].push_back({r[3:0], t[1:0]});
		@(posedge clk_sys) {scanStart, contextHighestRecord, scanEnable} <= {1'b1, hi, en};
		@(posedge clk_sys) scanStart <= 1'b0;
		repeat (2) @(posedge clk_sys);
		scanStart <= 1'b1; // restart while busy, must be ignored
		@(posedge clk_sys) scanStart <= 1'b0;
		w = 0;
		while (scanDoneFlag !== 1'b1 && w < 3000) begin
			@(posedge clk_sys);
			w++;
		end
		chk("done", 2'b10, {scanDoneFlag, scanBusy});
		chk("left", 0, gq[0].size() + gq[1].size());
		@(posedge clk_sys) scanDoneClr <= 1'b1;
		@(posedge clk_sys) scanDoneClr <= 1'b0;
		@(posedge clk_sys) chk("doneclr", 0, scanDoneFlag);
	endtask
	// ==========================================
	// clock, timeout and output watcher
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			errCount++;
			wrapUp;
		end
		for (int d = 0; d < 2; d++) begin
			if (genValid[d] === 1'b1 && genReady[d] === 1'b1) begin
				chk("cellq", 1, gq[d].size() != 0);
				e = gq[d].size() ? gq[d].pop_front() : 6'h00;
				chk("cell", {e, e[1:0] != 2'd2, 8'h6A}, {genConn[d], genType[d], genE2e[d], genFillOctet});
			end
			if (rxDoneValid[d] === 1'b1) begin
				chk("rxq", 1, rq[d].size() != 0);
				chk("rx", rq[d].size() ? rq[d].pop_front() : 2'b00, {rxCopy[d], rxRemove[d]});
			end
		end
	end
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'h9fec));
		{nrst, ctxWrEn, ctxWrDir, ctxWrIdx, ctxWrData, flgRdIdx, flgClrEn, flgClrIdx} = '0;
		{flgClrMask, scanStart, scanEnable, contextHighestRecord, scanDoneClr, slow} = '0;
		{rxValid, rxConn, rxKind, rxSegment} = '0;
		for (int i = 0; i < 16; i++) {sc[0][i], sc[1][i], ef[0][i], ef[1][i]} = '0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) wr(i % 2, i / 2, 9'($urandom));
		repeat (60) begin
			k = $urandom % 5;
			rx($urandom % 2, $urandom % 4, k, k != 0 && $urandom % 2);
		end
		rdall;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys) {flgClrEn, flgClrIdx, flgClrMask} <= {1'b1, i[3:0], 8'($urandom)};
			@(posedge clk_sys) flgClrEn <= 1'b0;
			{ef[1][i], ef[0][i]} = {ef[1][i], ef[0][i]} & ~flgClrMask;
		end
		rdall;
		scan(4'd3, 8'($urandom)); // random send-bit enables, scan walks records 3 down to 0
		scan(4'd3, 8'h00);
		slow <= 1'b1;
		scan(4'hF, 8'hFF);
		slow <= 1'b0;
		wrapUp;
	end
endmodule // test_oamfm_top
`default_nettype wire
